// [vdc_dma_regs.sv]
// Summary of operation
// - command bit 7 write launches transfer
// - abort after 16 ms, flag timeout
// - bit 5 selects transfer direction
// - bit 4 selects 32 or 64 bit
// - pause plus block releases per 64 bytes
// - block mode pauses per 256/512 bytes
// - bit 2 enables completion interrupt
// - done flag shows completion, cleared on start
// - writing done zero withdraws interrupt
// - local address advances by beat size
// - address read shows next access address
// - bit 31 at 0x12, bit 0 at 0x15
// - byte or word access only
// - packet count decrements, reads remaining
// - remote address split by bypass bit
// - remote address bytes 1a-1d (VME) or 1c-1f (PCI) increment
// - in VME mode 1f reads remote status, bit7 clears
module vdc_dma_regs
	import vdc_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYCLES_DFLT,
	parameter int          DATA_W         = 64
) (
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire vdc_io_req_t       io_req,
	output logic [15:0]            io_rdata,
	output logic                   io_ack,
	input  wire logic [7:0]        remote_status_pin,
	input  wire logic              remote_vme_pin,
	input  wire logic              map_bypass_pin,
	input  wire logic              src_valid,
	input  wire logic [DATA_W-1:0] src_data,
	output logic                   src_ready,
	output logic                   snk_valid,
	output logic [DATA_W-1:0]      snk_data,
	input  wire logic              snk_ready,
	output logic                   bus_req,
	output logic                   dma_dir,
	output logic                   dma_wide32,
	output logic [31:0]            local_bus_address,
	output logic [31:0]            far_addr,
	output logic [11:0]            far_map_sel,
	output logic                   dma_irq,
	output logic                   dma_done,
	output logic                   timeout_err,
	output logic                   remote_err_clear
);

	vdc_state_t  state;
	vdc_state_t  next_state;
	vdc_cmd_t    cmd;
	logic [7:0]  local_remainder_count;
	logic [15:0] local_packet_count;
	logic [7:0]  remote_pci_remainder_count;
	logic [7:0]  remote_vme_remainder_count;
	logic [31:0] remote_vme_address;
	logic [31:0] remote_pci_address;
	logic [23:0] issue_left;
	logic [9:0]  burst;
	logic [31:0] tmo_cnt;
	logic [1:0]  fill;
	logic [DATA_W-1:0] buf1;
	logic [DATA_W-1:0] snk_head;
	logic [9:0]  sync1;
	logic [9:0]  sync2;

	// synchronised pin levels
	wire [7:0] remote_status = sync2[9:2];
	wire       remote_vme    = sync2[1];
	wire       map_bypass    = sync2[0];

	// register access decode
	wire word_ok = ~io_req.word | ~io_req.addr[0];
	wire wr_go   = io_req.sel & io_req.wr & word_ok;
	wire rd_go   = io_req.sel & io_req.rd & word_ok;
	wire running = (state != ST_IDLE);

	function automatic logic wb(input logic [4:0] off);
		wb = wr_go & ((io_req.addr == off) | (io_req.word & ((io_req.addr | 5'h01) == off)));
	endfunction

	function automatic logic [7:0] wd(input logic [4:0] off);
		wd = (io_req.word & (io_req.addr == off)) ? io_req.wdata[15:8] : io_req.wdata[7:0];
	endfunction

	wire [7:0] cmd_wd   = wd(OFF_CMD);
	wire       cmd_wr   = wb(OFF_CMD);
	wire       start_go = cmd_wr & cmd_wd[CMD_START_BIT] & ~running;
	wire       done_clr = cmd_wr & ~cmd_wd[CMD_DONE_BIT];
	wire [7:0] stat_wd  = wd(OFF_RSTAT);
	wire       stat_clr = remote_vme & wb(OFF_RSTAT) & stat_wd[STAT_CLR_BIT];

	// data movement
	wire        src_acc   = src_valid & src_ready;
	wire        snk_acc   = snk_valid & snk_ready;
	wire [7:0]  beat      = cmd.wide32 ? BEAT32_BYTES : BEAT64_BYTES;
	wire [23:0] beat24    = {16'h0000, beat};
	wire [23:0] count24   = {local_packet_count, local_remainder_count};
	wire [23:0] count_dec = count24 - beat24;
	wire        cnt_zero  = (count24 == 24'h000000);
	wire        complete  = running & cnt_zero;
	wire        tmo_hit   = running & (tmo_cnt >= TIMEOUT_CYCLES - 1);
	wire        loc_step  = cmd.dir ? src_acc : snk_acc;
	wire        far_step  = cmd.dir ? snk_acc : src_acc;

	// bus release spacing
	wire [9:0] blk_lim    = cmd.wide32 ? BLOCK32_BYTES : BLOCK64_BYTES;
	wire [9:0] burst_lim  = ~cmd.block ? {2'b00, beat} : (cmd.pause ? PAUSE_BYTES : blk_lim);
	wire [9:0] next_burst = burst + {2'b00, beat};
	wire       burst_hit  = src_acc & (next_burst >= burst_lim);

	// two-entry buffer occupancy
	wire       push      = src_acc;
	wire       pop       = snk_acc;
	wire [1:0] fill_step = fill + {1'b0, push} - {1'b0, pop};
	wire [1:0] next_fill = tmo_hit ? 2'd0 : fill_step;
	wire [23:0] next_issue = start_go ? count24 : (src_acc ? issue_left - beat24 : issue_left);

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (start_go)
					next_state = ST_RUN;
			end
			ST_RUN: begin
				if (complete | tmo_hit)
					next_state = ST_IDLE;
				else if (burst_hit)
					next_state = ST_PAUSE;
			end
			ST_PAUSE: begin
				if (complete | tmo_hit)
					next_state = ST_IDLE;
				else
					next_state = ST_RUN;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	function automatic logic [7:0] rb(input logic [4:0] off);
		case (off)
			OFF_CMD:          rb = {running, 1'b0, cmd.dir, cmd.wide32, cmd.pause, cmd.irq_en, dma_done, cmd.block};
			OFF_LREM:         rb = local_remainder_count;
			OFF_LADDR:        rb = local_bus_address[31:24];
			OFF_LADDR + 5'h1: rb = local_bus_address[23:16];
			OFF_LADDR + 5'h2: rb = local_bus_address[15:8];
			OFF_LADDR + 5'h3: rb = local_bus_address[7:0];
			OFF_PKT:          rb = local_packet_count[15:8];
			OFF_PKT + 5'h1:   rb = local_packet_count[7:0];
			OFF_RPREM:        rb = remote_vme ? BYTE_RST : remote_pci_remainder_count;
			OFF_RVREM:        rb = remote_vme ? remote_vme_remainder_count : BYTE_RST;
			OFF_RVADDR:       rb = remote_vme ? remote_vme_address[31:24] : BYTE_RST;
			OFF_RVADDR + 5'h1: rb = remote_vme ? remote_vme_address[23:16] : BYTE_RST;
			OFF_RPADDR:       rb = remote_vme ? remote_vme_address[15:8] : remote_pci_address[15:8];
			OFF_RPADDR + 5'h1: rb = remote_vme ? remote_vme_address[7:0] : remote_pci_address[7:0];
			OFF_RPADDR + 5'h2: rb = remote_vme ? BYTE_RST : remote_pci_address[31:24];
			OFF_RSTAT:        rb = remote_vme ? remote_status : remote_pci_address[23:16];
			default:          rb = BYTE_RST;
		endcase
	endfunction

	wire [15:0] rd_word = io_req.word ? {rb(io_req.addr), rb(io_req.addr | 5'h01)} : {8'h00, rb(io_req.addr)};

	assign snk_data   = snk_head;
	assign dma_dir    = cmd.dir;
	assign dma_wide32 = cmd.wide32;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sync1 <= 10'h000;
			sync2 <= 10'h000;
		end else begin
			sync1 <= {remote_status_pin, remote_vme_pin, map_bypass_pin};
			sync2 <= sync1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			io_ack   <= 1'b0;
			io_rdata <= 16'h0000;
		end else begin
			io_ack   <= io_req.sel & (io_req.rd | io_req.wr);
			io_rdata <= rd_go ? rd_word : 16'h0000;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state      <= ST_IDLE;
			issue_left <= 24'h000000;
			fill       <= 2'd0;
			src_ready  <= 1'b0;
			snk_valid  <= 1'b0;
			bus_req    <= 1'b0;
		end else begin
			state      <= next_state;
			issue_left <= tmo_hit ? 24'h000000 : next_issue;
			fill       <= next_fill;
			src_ready  <= (next_state == ST_RUN) & (next_fill < 2'd2) & (next_issue != 24'h000000);
			snk_valid  <= (next_fill != 2'd0);
			bus_req    <= (next_state == ST_RUN);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			snk_head <= '0;
			buf1     <= '0;
		end else if (push & (~pop | (fill == 2'd2))) begin
			if (fill == 2'd0)
				snk_head <= src_data;
			else if (pop)
				snk_head <= buf1;
			if (fill != 2'd0)
				buf1 <= src_data;
		end else if (pop) begin
			snk_head <= push ? src_data : buf1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			burst   <= 10'h000;
			tmo_cnt <= 32'h0000_0000;
		end else begin
			burst   <= (~running | burst_hit) ? 10'h000 : (src_acc ? next_burst : burst);
			tmo_cnt <= running ? tmo_cnt + 32'h0000_0001 : 32'h0000_0000;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cmd <= CMD_RST;
		end else if (cmd_wr & ~running) begin
			cmd        <= cmd_wd;
			cmd.start  <= 1'b0;
			cmd.rsvd   <= 1'b0;
			cmd.done   <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			dma_done    <= 1'b0;
			dma_irq     <= 1'b0;
			timeout_err <= 1'b0;
		end else begin
			dma_done    <= complete | (dma_done & ~done_clr & ~start_go);
			dma_irq     <= (complete & cmd.irq_en) | (dma_irq & ~done_clr & ~start_go);
			timeout_err <= tmo_hit | (timeout_err & ~start_go & ~stat_clr);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			local_remainder_count <= BYTE_RST;
			local_packet_count    <= 16'h0000;
		end else if (running) begin
			if (snk_acc)
				{local_packet_count, local_remainder_count} <= count_dec;
		end else begin
			if (wb(OFF_LREM))
				local_remainder_count <= wd(OFF_LREM);
			for (int i = 0; i < 2; i++)
				if (wb(5'(OFF_PKT + i)))
					local_packet_count[8*(1-i) +: 8] <= wd(5'(OFF_PKT + i));
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			local_bus_address <= ADDR_RST;
		end else if (running) begin
			if (loc_step)
				local_bus_address <= local_bus_address + {24'h000000, beat};
		end else begin
			for (int i = 0; i < 4; i++)
				if (wb(5'(OFF_LADDR + i)))
					local_bus_address[8*(3-i) +: 8] <= wd(5'(OFF_LADDR + i));
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			remote_vme_address <= ADDR_RST;
			remote_pci_address <= ADDR_RST;
		end else if (running) begin
			if (far_step & remote_vme)
				remote_vme_address <= remote_vme_address + {24'h000000, beat};
			if (far_step & ~remote_vme)
				remote_pci_address <= remote_pci_address + {24'h000000, beat};
		end else if (remote_vme) begin
			for (int i = 0; i < 4; i++)
				if (wb(5'(OFF_RVADDR + i)))
					remote_vme_address[8*(3-i) +: 8] <= wd(5'(OFF_RVADDR + i));
		end else begin
			if (wb(OFF_RPADDR))
				remote_pci_address[15:8] <= wd(OFF_RPADDR);
			if (wb(OFF_RPADDR + 5'h1))
				remote_pci_address[7:0] <= wd(OFF_RPADDR + 5'h1);
			if (wb(OFF_RPADDR + 5'h2))
				remote_pci_address[31:24] <= wd(OFF_RPADDR + 5'h2);
			if (wb(OFF_RSTAT))
				remote_pci_address[23:16] <= wd(OFF_RSTAT);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			remote_pci_remainder_count <= BYTE_RST;
			remote_vme_remainder_count <= BYTE_RST;
		end else if (~running) begin
			if (~remote_vme & wb(OFF_RPREM))
				remote_pci_remainder_count <= wd(OFF_RPREM);
			if (remote_vme & wb(OFF_RVREM))
				remote_vme_remainder_count <= wd(OFF_RVREM);
		end
	end

	// far start address: low 12 bits always, upper bits only for VME or when mapping is bypassed
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			far_addr         <= ADDR_RST;
			far_map_sel      <= 12'h000;
			remote_err_clear <= 1'b0;
		end else begin
			far_addr         <= remote_vme ? remote_vme_address :
				(map_bypass ? remote_pci_address : {20'h00000, remote_pci_address[11:0]});
			far_map_sel      <= (remote_vme | map_bypass) ? 12'h000 : remote_pci_address[23:12];
			remote_err_clear <= stat_clr;
		end
	end

endmodule

// [vdc_pkg.sv]
package vdc_pkg;

	// register offsets inside the 32-byte I/O window
	localparam logic [4:0] OFF_CMD    = 5'h10;
	localparam logic [4:0] OFF_LREM   = 5'h11;
	localparam logic [4:0] OFF_LADDR  = 5'h12;
	localparam logic [4:0] OFF_PKT    = 5'h16;
	localparam logic [4:0] OFF_RPREM  = 5'h18;
	localparam logic [4:0] OFF_RVREM  = 5'h19;
	localparam logic [4:0] OFF_RVADDR = 5'h1a;
	localparam logic [4:0] OFF_RPADDR = 5'h1c;
	localparam logic [4:0] OFF_RSTAT  = 5'h1f;

	// command and status byte bit positions
	localparam int CMD_START_BIT = 7;
	localparam int CMD_DONE_BIT  = 1;
	localparam int STAT_CLR_BIT  = 7;

	// values after reset
	localparam logic [7:0]  CMD_RST  = 8'h00;
	localparam logic [7:0]  BYTE_RST = 8'h00;
	localparam logic [31:0] ADDR_RST = 32'h0000_0000;

	// transfer sizes in bytes
	localparam logic [7:0] BEAT32_BYTES  = 8'h04;
	localparam logic [7:0] BEAT64_BYTES  = 8'h08;
	localparam logic [9:0] PAUSE_BYTES   = 10'h040;
	localparam logic [9:0] BLOCK32_BYTES = 10'h100;
	localparam logic [9:0] BLOCK64_BYTES = 10'h200;

	// transfer timeout
	localparam int unsigned TIMEOUT_MS          = 16;
	localparam int unsigned CLK_HZ              = 50000000;
	localparam int unsigned TIMEOUT_CYCLES_DFLT = TIMEOUT_MS * (CLK_HZ / 1000);

	typedef struct packed {
		logic start;
		logic rsvd;
		logic dir;
		logic wide32;
		logic pause;
		logic irq_en;
		logic done;
		logic block;
	} vdc_cmd_t;

	typedef struct packed {
		logic        sel;
		logic        rd;
		logic        wr;
		logic        word;
		logic [4:0]  addr;
		logic [15:0] wdata;
	} vdc_io_req_t;

	typedef enum {ST_IDLE, ST_RUN, ST_PAUSE} vdc_state_t;

endpackage

// [vdc_chk_sva.sv]
module vdc_chk
	import vdc_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rst,
	input wire vdc_io_req_t io_req,
	input wire logic        io_ack,
	input wire logic        src_valid,
	input wire logic        src_ready,
	input wire logic        bus_req,
	input wire logic        dma_irq,
	input wire logic        dma_done,
	input wire logic        timeout_err,
	input wire logic        remote_err_clear
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       cmd_wr;
	logic [7:0] run_beats;
	assign cmd_wr = io_req.sel && io_req.wr && !io_req.word && io_req.addr == OFF_CMD;
	// beats taken since the bus was last let go
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			run_beats <= 8'h00;
		else if (!bus_req)
			run_beats <= 8'h00;
		else if (src_valid && src_ready)
			run_beats <= run_beats + 8'h01;
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	chk_ack_follow: assert property (io_ack == $past(io_req.sel && (io_req.rd || io_req.wr)))
		else $error("io_ack does not follow the access");
	chk_beat_bound: assert property (run_beats <= 8'h40)
		else $error("too many beats without a pause");
	chk_pause_quiet: assert property (!bus_req |-> !src_ready)
		else $error("source taken while bus released");
	chk_irq_done: assert property (dma_irq |-> dma_done)
		else $error("interrupt without done flag");
	chk_done_clear: assert property (cmd_wr && !io_req.wdata[1] |=> !dma_done && !dma_irq)
		else $error("done or interrupt survived a clear");
	chk_start_clear: assert property (cmd_wr && io_req.wdata[7] |=> !dma_done && !timeout_err)
		else $error("flags not cleared by start");
	chk_done_idle: assert property ($rose(dma_done) |-> !bus_req && !src_ready)
		else $error("done while still moving data");
	chk_timeout_stop: assert property ($rose(timeout_err) |-> !bus_req && !dma_done)
		else $error("timeout without abort");
	chk_clear_pulse: assert property (remote_err_clear |=> !remote_err_clear && !timeout_err)
		else $error("error clear not a single pulse");
	cover property ($rose(dma_done));
	cover property ($rose(timeout_err));
	cover property (remote_err_clear);
endmodule

bind vdc_dma_regs vdc_chk u_chk (
	.mclk            (mclk),
	.rst             (rst),
	.io_req          (io_req),
	.io_ack          (io_ack),
	.src_valid       (src_valid),
	.src_ready       (src_ready),
	.bus_req         (bus_req),
	.dma_irq         (dma_irq),
	.dma_done        (dma_done),
	.timeout_err     (timeout_err),
	.remote_err_clear(remote_err_clear)
);

// [vdc_far.sv]
module vdc_far
	import vdc_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        stall,
	input  wire logic        src_ready,
	input  wire logic        snk_valid,
	input  wire logic [63:0] snk_data,
	output logic             src_valid,
	output logic [63:0]      src_data,
	output logic             snk_ready,
	output logic [15:0]      rx_cnt,
	output logic             rx_bad
);
	timeunit 1ns;
	timeprecision 1ns;
	// far memory only, never the dual-port store
	logic [63:0] seq;
	logic [63:0] rx_seq;
	assign src_valid = !stall;
	assign snk_ready = !stall;
	// released data lines show the inverse, never a stale word
	assign src_data = src_valid ? seq : ~seq;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			seq <= 64'h0;
			rx_cnt <= 16'h0;
			rx_seq <= 64'h0;
			rx_bad <= 1'b0;
		end else begin
			if (src_valid && src_ready)
				seq <= seq + 64'h1;
			if (snk_valid && snk_ready) begin
				rx_cnt <= rx_cnt + 16'h1;
				rx_seq <= rx_seq + 64'h1;
				// words must arrive whole and in order
				if (snk_data !== rx_seq)
					rx_bad <= 1'b1;
			end
		end
	end
endmodule

// [vdc_dma_regs_bench.sv]
module vdc_dma_regs_bench;
	import vdc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk;
	logic        rst;
	vdc_io_req_t io_req;
	logic [15:0] io_rdata;
	logic        io_ack;
	logic        src_valid;
	logic [63:0] src_data;
	logic        src_ready;
	logic        snk_valid;
	logic [63:0] snk_data;
	logic        snk_ready;
	logic        bus_req;
	logic        dma_dir;
	logic        dma_wide32;
	logic [31:0] local_bus_address;
	logic        dma_irq;
	logic        dma_done;
	logic        timeout_err;
	logic        remote_err_clear;
	logic        stall;
	logic [15:0] rx_cnt;
	logic        rx_bad;
	logic [31:0] far_addr;
	logic [11:0] far_map_sel;
	logic        remote_vme;
	logic        map_bypass;
	logic [15:0] q;
	int          n_mismatch;
	int          total_checks;
	vdc_dma_regs #(.TIMEOUT_CYCLES(2000), .DATA_W(64)) u_dut (
		.mclk(mclk), .rst(rst), .io_req(io_req), .io_rdata(io_rdata), .io_ack(io_ack),
		.remote_status_pin(8'h5a), .remote_vme_pin(remote_vme), .map_bypass_pin(map_bypass),
		.src_valid(src_valid), .src_data(src_data), .src_ready(src_ready),
		.snk_valid(snk_valid), .snk_data(snk_data), .snk_ready(snk_ready),
		.bus_req(bus_req), .dma_dir(dma_dir), .dma_wide32(dma_wide32),
		.local_bus_address(local_bus_address), .far_addr(far_addr), .far_map_sel(far_map_sel),
		.dma_irq(dma_irq), .dma_done(dma_done), .timeout_err(timeout_err),
		.remote_err_clear(remote_err_clear)
	);
	vdc_far u_far (
		.mclk(mclk), .rst(rst), .stall(stall), .src_ready(src_ready),
		.snk_valid(snk_valid), .snk_data(snk_data), .src_valid(src_valid),
		.src_data(src_data), .snk_ready(snk_ready), .rx_cnt(rx_cnt), .rx_bad(rx_bad)
	);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic hang;
		n_mismatch++;
		summarize();
	endtask
	task automatic io(input logic w, input logic wd, input logic [4:0] a, input logic [15:0] d);
		int i;
		@(posedge mclk);
		io_req <= '{1'b1, !w, w, wd, a, d};
		@(posedge mclk);
		io_req.sel <= 1'b0;
		for (i = 0; i < 4; i++) begin
			@(negedge mclk);
			if (io_ack === 1'b1)
				break;
		end
		if (i == 4)
			hang();
		q = io_rdata;
	endtask
	task automatic s_regs;
		io(0, 0, OFF_CMD, 16'h0);
		chk(q, {8'h00, CMD_RST});
		io(1, 1, OFF_LADDR, 16'h89ab);
		io(0, 0, OFF_LADDR, 16'h0);
		chk(q, 16'h0089);
		io(0, 1, OFF_LADDR, 16'h0);
		chk(q, 16'h89ab);
		io(1, 1, OFF_RVADDR, 16'h1234);
		io(0, 1, OFF_RVADDR, 16'h0);
		chk(q, 16'h1234);
		io(0, 0, 5'h1e, 16'h0);
		chk(q, 16'h0000);
	endtask
	task automatic s_xfer(input logic [7:0] cmd, input logic slow);
		int i;
		logic [15:0] rx0;
		rx0 = rx_cnt;
		io(1, 0, OFF_LREM, 16'h0040);
		io(1, 0, OFF_RVREM, 16'h0040);
		io(1, 1, OFF_LADDR, 16'h89ab);
		io(1, 1, OFF_LADDR + 5'h2, 16'hcde0);
		io(1, 1, OFF_RVADDR + 5'h2, 16'h0000);
		io(1, 1, OFF_PKT, 16'h0001);
		chk(local_bus_address, 32'h89abcde0);
		io(1, 0, OFF_CMD, {8'h00, cmd | 8'h80});
		chk({dma_dir, dma_wide32}, cmd[5:4]);
		io(0, 1, OFF_PKT, 16'h0);
		chk(q, 16'h0001);
		for (i = 0; i < 4000 && dma_done !== 1'b1; i++) begin
			@(posedge mclk);
			stall <= slow && !stall;
			@(negedge mclk);
		end
		stall <= 1'b0;
		if (dma_done !== 1'b1)
			hang();
		chk(rx_cnt - rx0, cmd[4] ? 16'h0050 : 16'h0028);
		chk(rx_bad, 1'b0);
		chk(local_bus_address, 32'h89abcf20);
		chk(dma_irq, cmd[2]);
		io(0, 1, OFF_RVADDR + 5'h2, 16'h0);
		chk(q, 16'h0140);
		io(0, 1, OFF_PKT, 16'h0);
		chk(q, 16'h0000);
		io(0, 0, OFF_CMD, 16'h0);
		chk(q, {10'h000, cmd[5:2], 1'b1, cmd[0]});
		io(1, 0, OFF_CMD, 16'h0);
		chk({dma_done, dma_irq}, 2'b00);
	endtask
	task automatic s_timeout;
		int i;
		stall <= 1'b1;
		io(1, 1, OFF_PKT, 16'h0001);
		io(1, 0, OFF_CMD, 16'h0080);
		for (i = 0; i < 3000 && timeout_err !== 1'b1; i++)
			@(negedge mclk);
		if (timeout_err !== 1'b1)
			hang();
		chk(timeout_err, 1'b1);
		chk(dma_done, 1'b0);
		io(0, 0, OFF_RSTAT, 16'h0);
		chk(q, 16'h005a);
		io(1, 0, OFF_RSTAT, 16'h0080);
		chk(timeout_err, 1'b0);
		stall <= 1'b0;
	endtask
	task automatic s_pci;
		@(posedge mclk);
		remote_vme <= 1'b0;
		map_bypass <= 1'b0;
		repeat (2) @(posedge mclk);
		io(1, 1, OFF_RPADDR, 16'h5678);
		io(1, 1, OFF_RPADDR + 5'h2, 16'h9abc);
		io(0, 1, OFF_RPADDR, 16'h0);
		chk(q, 16'h5678);
		io(0, 1, OFF_RPADDR + 5'h2, 16'h0);
		chk(q, 16'h9abc);
		chk(far_addr, 32'h0000_0678);
		chk(far_map_sel, 12'hbc5);
		io(1, 0, OFF_RPREM, 16'h0040);
		io(0, 0, OFF_RPREM, 16'h0);
		chk(q, 16'h0040);
		io(0, 0, OFF_RVREM, 16'h0);
		chk(q, 16'h0000);
		@(posedge mclk);
		map_bypass <= 1'b1;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		chk(far_addr, 32'h9abc_5678);
		chk(far_map_sel, 12'h000);
	endtask
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		rst = 1'b1;
		io_req = '0;
		stall = 1'b0;
		remote_vme = 1'b1;
		map_bypass = 1'b0;
		n_mismatch = 0;
		total_checks = 0;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		s_regs();
		s_xfer(8'h34, 1'b0);
		s_xfer(8'h01, 1'b1);
		s_xfer(8'h19, 1'b1);
		s_xfer(8'h24, 1'b0);
		s_timeout();
		s_pci();
		summarize();
	end
endmodule
